// ===== include/can_tx_pkg.sv
// holds constants, enumerations and carriers of the transmit buffer block
// assumes one 20 MHz apb clock domain shared with the protocol engine
// ===========================================================================
// package
package can_tx_pkg;

  localparam int NUM_BUF = 64;                // buffers per channel
  localparam int IDX_W   = 6;                 // buffer index width

  // =========================================================================
  // register map, byte addresses of 32-bit words
  localparam logic [11:0] OFS_CTRL   = 12'h000; // tx_buffer_control array
  localparam logic [11:0] OFS_STAT   = 12'h100; // tx_buffer_status array
  localparam logic [11:0] OFS_ID     = 12'h200; // tx_identifier array
  localparam logic [11:0] OFS_DATA   = 12'h300; // tx_data_word array
  localparam logic [11:0] OFS_IEN_LO = 12'h400; // tx_irq_enable_group 0
  localparam logic [11:0] OFS_IEN_HI = 12'h404; // tx_irq_enable_group 1
  localparam logic [11:0] OFS_CHCTL  = 12'h408; // channel_control
  localparam logic [11:0] OFS_HIST   = 12'h40c; // history_config

  // =========================================================================
  // field positions
  localparam int CTRL_REQ_BIT  = 0;           // tx_request_bit
  localparam int CTRL_ABT_BIT  = 1;           // tx_abort_request_bit
  localparam int CTRL_SS_BIT   = 2;           // single_shot_enable
  localparam int STAT_RES_LSB  = 0;           // tx_result_field [1:0]
  localparam int STAT_PEND_BIT = 2;           // tx_request_pending
  localparam int CHCTL_MODE_LSB = 0;          // channel mode [1:0]
  localparam int CHCTL_AIE_BIT = 8;           // abort_irq_enable
  localparam int HIST_DTE_BIT  = 0;           // history_data_enable
  localparam int HIST_EN_BIT   = 1;           // history_enable
  localparam int ID_HIST_BIT   = 31;          // history_store_flag

  // =========================================================================
  // enumerations
  typedef enum logic [1:0] {
    RES_NONE     = 2'b00,
    RES_ABORTED  = 2'b01,
    RES_DONE     = 2'b10,
    RES_DONE_ABT = 2'b11
  } result_type;

  typedef enum logic [1:0] {
    MODE_COMM    = 2'b00,
    MODE_RESET   = 2'b01,
    MODE_HALT    = 2'b10,
    MODE_STANDBY = 2'b11
  } mode_type;

  typedef enum logic {
    LK_IDLE = 1'b0,
    LK_HELD = 1'b1
  } lock_state_type;

  // =========================================================================
  // reset values
  localparam mode_type   RST_MODE = MODE_RESET;
  localparam result_type RST_RES  = RES_NONE;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // =========================================================================
  // carriers
  typedef struct packed {
    logic start;       // engine has chosen the offered buffer
    logic done;        // chosen message sent without loss or error
    logic arb_lost;    // chosen message lost arbitration
    logic error;       // bus error on chosen message
  } eng_event_type;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
  } tx_sel_type;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
    logic [28:0]      id;
    logic [31:0]      data;
  } tx_offer_type;

endpackage : can_tx_pkg

// ===== hdl/tx_select.sv
// picks the lowest numbered buffer among the candidates
// assumes candidates come from flip-flops of the same clock
// ===========================================================================
// buffer number priority selector
module tx_select (
  input  wire logic [can_tx_pkg::NUM_BUF-1:0] cand,
  output can_tx_pkg::tx_sel_type              sel
);

  // scan from the top so the lowest index is written last and wins
  always_comb begin
    sel = '0;
    for (int k = can_tx_pkg::NUM_BUF - 1; k >= 0; k--) begin
      if (cand[k]) begin
        sel.valid = 1'b1;
        sel.index = k[can_tx_pkg::IDX_W-1:0];
      end
    end
  end

endmodule : tx_select

// ===== hdl/can_tx_buffer_control.sv
// transmit buffer control of one can channel with an apb register slave
// assumes a protocol engine on pclk that takes offers and reports outcomes
module can_tx_buffer_control (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  can_tx_pkg::eng_event_type  eng_ev,
  output can_tx_pkg::tx_offer_type   offer,
  output logic                       tx_irq,
  output can_tx_pkg::tx_sel_type     hist_push
);

  localparam int NB = can_tx_pkg::NUM_BUF;
  localparam int IW = can_tx_pkg::IDX_W;

  // =========================================================================
  // state
  logic [NB-1:0]                     req_r, req_nxt;
  logic [NB-1:0]                     abt_r, abt_nxt;
  logic [NB-1:0]                     ss_r, ss_nxt;
  can_tx_pkg::result_type [NB-1:0]   res_r, res_nxt;
  logic [NB-1:0][31:0]               id_r, id_nxt;
  logic [NB-1:0][31:0]               data_r, data_nxt;
  logic [NB-1:0]                     ien_r, ien_nxt;
  logic [NB-1:0]                     dn, ab;
  can_tx_pkg::mode_type              mode_r, mode_nxt;
  logic                              aie_r, aie_nxt;
  logic                              hdte_r, hdte_nxt;
  logic                              hen_r, hen_nxt;
  can_tx_pkg::lock_state_type        lk_st_r, lk_st_nxt;
  logic [IW-1:0]                     lk_idx_r, lk_idx_nxt;
  can_tx_pkg::tx_offer_type          offer_r, offer_nxt;
  can_tx_pkg::tx_sel_type            hist_r, hist_nxt, sel;
  logic                              irq_r, irq_nxt;
  logic [31:0]                       prdata_r, prdata_nxt;
  logic [31:0]                       rd_word;
  logic                              rd_err;
  logic                              wr_acc, mode_ok, accept, outcome;
  logic [11:0]                       region;
  logic [IW-1:0]                     bidx;

  // =========================================================================
  // apb decode; zero wait states so every access ends in one cycle
  assign region  = {paddr[11:8], 8'h00};
  assign bidx    = paddr[7:2];
  assign wr_acc  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & rd_err;
  assign prdata  = prdata_r;
  assign mode_ok = (mode_r == can_tx_pkg::MODE_COMM) ||
                   (mode_r == can_tx_pkg::MODE_STANDBY);
  assign outcome = eng_ev.done | eng_ev.arb_lost | eng_ev.error;
  assign accept  = eng_ev.start & offer_r.valid &
                   (lk_st_r == can_tx_pkg::LK_IDLE) & req_r[offer_r.index];

  // read mux; unaligned or unmapped addresses read zero with an error
  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (region == can_tx_pkg::OFS_CTRL) begin
      rd_word[can_tx_pkg::CTRL_REQ_BIT] = req_r[bidx];
      rd_word[can_tx_pkg::CTRL_ABT_BIT] = abt_r[bidx];
      rd_word[can_tx_pkg::CTRL_SS_BIT]  = ss_r[bidx];
    end else if (region == can_tx_pkg::OFS_STAT) begin
      rd_word[can_tx_pkg::STAT_RES_LSB +: 2] = res_r[bidx];
      rd_word[can_tx_pkg::STAT_PEND_BIT]     = req_r[bidx];
    end else if (region == can_tx_pkg::OFS_ID) begin
      rd_word = id_r[bidx];
    end else if (region == can_tx_pkg::OFS_DATA) begin
      rd_word = data_r[bidx];
    end else if (paddr == can_tx_pkg::OFS_IEN_LO) begin
      rd_word = ien_r[31:0];
    end else if (paddr == can_tx_pkg::OFS_IEN_HI) begin
      rd_word = ien_r[63:32];
    end else if (paddr == can_tx_pkg::OFS_CHCTL) begin
      rd_word[can_tx_pkg::CHCTL_MODE_LSB +: 2] = mode_r;
      rd_word[can_tx_pkg::CHCTL_AIE_BIT]       = aie_r;
    end else if (paddr == can_tx_pkg::OFS_HIST) begin
      rd_word[can_tx_pkg::HIST_DTE_BIT] = hdte_r;
      rd_word[can_tx_pkg::HIST_EN_BIT]  = hen_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  // =========================================================================
  // per buffer request, abort and result logic
  for (genvar i = 0; i < NB; i++) begin : g_buf
    logic lk, chosen, wr_ctl, wr_stat, wr_id, wr_dat;
    assign lk      = (lk_st_r == can_tx_pkg::LK_HELD) &&
                     (lk_idx_r == IW'(i));
    assign chosen  = lk | (accept && (offer_r.index == IW'(i)));
    assign wr_ctl  = wr_acc && (region == can_tx_pkg::OFS_CTRL) &&
                     (bidx == IW'(i)) && mode_ok;
    assign wr_stat = wr_acc && (region == can_tx_pkg::OFS_STAT) &&
                     (bidx == IW'(i)) && mode_ok;
    assign wr_id   = wr_acc && (region == can_tx_pkg::OFS_ID) &&
                     (bidx == IW'(i)) && !req_r[i];
    assign wr_dat  = wr_acc && (region == can_tx_pkg::OFS_DATA) &&
                     (bidx == IW'(i)) && !req_r[i];

    // clears and writes first, hardware outcomes last so an outcome wins over a write
    always_comb begin
      req_nxt[i]  = req_r[i];
      abt_nxt[i]  = abt_r[i];
      ss_nxt[i]   = ss_r[i];
      res_nxt[i]  = res_r[i];
      id_nxt[i]   = wr_id ? pwdata : id_r[i];
      data_nxt[i] = wr_dat ? pwdata : data_r[i];
      dn[i]       = 1'b0;
      ab[i]       = 1'b0;
      if (wr_stat && !req_r[i] &&
          pwdata[can_tx_pkg::STAT_RES_LSB +: 2] == can_tx_pkg::RES_NONE) begin
        res_nxt[i] = can_tx_pkg::RES_NONE;
      end
      if (wr_ctl && !req_r[i]) begin
        // a zero control word leaves a linked buffer inert
        if (pwdata[can_tx_pkg::CTRL_REQ_BIT] &&
            res_r[i] == can_tx_pkg::RES_NONE) begin
          req_nxt[i] = 1'b1;
          ss_nxt[i]  = pwdata[can_tx_pkg::CTRL_SS_BIT];
        end
      end else if (wr_ctl && pwdata[can_tx_pkg::CTRL_ABT_BIT]) begin
        abt_nxt[i] = 1'b1;
      end
      if (req_r[i]) begin
        if (lk && eng_ev.done) begin
          res_nxt[i] = abt_r[i] ? can_tx_pkg::RES_DONE_ABT
                                : can_tx_pkg::RES_DONE;
          req_nxt[i] = 1'b0;
          abt_nxt[i] = 1'b0;
          ss_nxt[i]  = 1'b0;
          dn[i]      = 1'b1;
        end else if (lk && (eng_ev.arb_lost || eng_ev.error)) begin
          // normal mode keeps the request so the engine retries
          if (abt_r[i] || ss_r[i]) begin
            res_nxt[i] = can_tx_pkg::RES_ABORTED;
            req_nxt[i] = 1'b0;
            abt_nxt[i] = 1'b0;
            ss_nxt[i]  = 1'b0;
            ab[i]      = 1'b1;
          end
        end else if (!chosen && abt_r[i]) begin
          res_nxt[i] = can_tx_pkg::RES_ABORTED;
          req_nxt[i] = 1'b0;
          abt_nxt[i] = 1'b0;
          ss_nxt[i]  = 1'b0;
          ab[i]      = 1'b1;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        req_r[i]  <= 1'b0;
        abt_r[i]  <= 1'b0;
        ss_r[i]   <= 1'b0;
        res_r[i]  <= can_tx_pkg::RST_RES;
        id_r[i]   <= can_tx_pkg::RST_WORD;
        data_r[i] <= can_tx_pkg::RST_WORD;
      end else begin
        req_r[i]  <= req_nxt[i];
        abt_r[i]  <= abt_nxt[i];
        ss_r[i]   <= ss_nxt[i];
        res_r[i]  <= res_nxt[i];
        id_r[i]   <= id_nxt[i];
        data_r[i] <= data_nxt[i];
      end
    end
  end

  // =========================================================================
  // channel settings and interrupt enables
  always_comb begin
    ien_nxt  = ien_r;
    mode_nxt = mode_r;
    aie_nxt  = aie_r;
    hdte_nxt = hdte_r;
    hen_nxt  = hen_r;
    if (wr_acc && paddr == can_tx_pkg::OFS_IEN_LO) begin
      ien_nxt[31:0] = pwdata;
    end
    if (wr_acc && paddr == can_tx_pkg::OFS_IEN_HI) begin
      ien_nxt[63:32] = pwdata;
    end
    if (wr_acc && paddr == can_tx_pkg::OFS_CHCTL) begin
      mode_nxt = can_tx_pkg::mode_type'(
                   pwdata[can_tx_pkg::CHCTL_MODE_LSB +: 2]);
      aie_nxt  = pwdata[can_tx_pkg::CHCTL_AIE_BIT];
    end
    if (wr_acc && paddr == can_tx_pkg::OFS_HIST) begin
      hdte_nxt = pwdata[can_tx_pkg::HIST_DTE_BIT];
      hen_nxt  = pwdata[can_tx_pkg::HIST_EN_BIT];
    end
  end

  // =========================================================================
  // engine lock: the chosen buffer stays protected until its outcome
  always_comb begin
    lk_st_nxt  = lk_st_r;
    lk_idx_nxt = lk_idx_r;
    case (lk_st_r)
      can_tx_pkg::LK_IDLE: begin
        if (accept) begin
          lk_st_nxt  = can_tx_pkg::LK_HELD;
          lk_idx_nxt = offer_r.index;
        end
      end
      can_tx_pkg::LK_HELD: begin
        if (outcome) begin
          lk_st_nxt = can_tx_pkg::LK_IDLE;
        end
      end
      default: begin
        lk_st_nxt = can_tx_pkg::LK_IDLE;
      end
    endcase
  end

  // buffers with an abort on the way are not offered again
  tx_select u_select (
    .cand (req_r & ~abt_r),
    .sel  (sel)
  );

  // offer, interrupt and history outputs, all registered
  always_comb begin
    offer_nxt       = '0;
    offer_nxt.valid = sel.valid && (lk_st_nxt == can_tx_pkg::LK_IDLE);
    offer_nxt.index = sel.index;
    offer_nxt.id    = id_r[sel.index][28:0];
    offer_nxt.data  = data_r[sel.index];
    irq_nxt = (|(dn & ien_r)) | (aie_r & (|ab));
    hist_nxt.valid = (|dn) && hdte_r && hen_r &&
                     id_r[lk_idx_r][can_tx_pkg::ID_HIST_BIT];
    hist_nxt.index = lk_idx_r;
    prdata_nxt = (psel && !penable) ? rd_word : prdata_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r    <= '0;
      mode_r   <= can_tx_pkg::RST_MODE;
      aie_r    <= 1'b0;
      hdte_r   <= 1'b0;
      hen_r    <= 1'b0;
      lk_st_r  <= can_tx_pkg::LK_IDLE;
      lk_idx_r <= '0;
      offer_r  <= '0;
      irq_r    <= 1'b0;
      hist_r   <= '0;
      prdata_r <= can_tx_pkg::RST_WORD;
    end else begin
      ien_r    <= ien_nxt;
      mode_r   <= mode_nxt;
      aie_r    <= aie_nxt;
      hdte_r   <= hdte_nxt;
      hen_r    <= hen_nxt;
      lk_st_r  <= lk_st_nxt;
      lk_idx_r <= lk_idx_nxt;
      offer_r  <= offer_nxt;
      irq_r    <= irq_nxt;
      hist_r   <= hist_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign offer     = offer_r;
  assign tx_irq    = irq_r;
  assign hist_push = hist_r;

  // =========================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_done_plain;
    lk_st_r == can_tx_pkg::LK_HELD && eng_ev.done && !abt_r[lk_idx_r]
    |=> res_r[$past(lk_idx_r)] == can_tx_pkg::RES_DONE &&
        !req_r[$past(lk_idx_r)];
  endproperty
  a_done_plain: assert property (p_done_plain)
    else $error("plain completion did not give result 10");

  property p_done_abt;
    lk_st_r == can_tx_pkg::LK_HELD && eng_ev.done && abt_r[lk_idx_r]
    |=> res_r[$past(lk_idx_r)] == can_tx_pkg::RES_DONE_ABT;
  endproperty
  a_done_abt: assert property (p_done_abt)
    else $error("completion after abort did not give result 11");

  property p_retry;
    lk_st_r == can_tx_pkg::LK_HELD && eng_ev.arb_lost &&
    !abt_r[lk_idx_r] && !ss_r[lk_idx_r]
    |=> req_r[$past(lk_idx_r)] && lk_st_r == can_tx_pkg::LK_IDLE;
  endproperty
  a_retry: assert property (p_retry)
    else $error("normal message dropped after arbitration loss");

  property p_single_shot;
    lk_st_r == can_tx_pkg::LK_HELD && (eng_ev.arb_lost || eng_ev.error) &&
    ss_r[lk_idx_r]
    |=> res_r[$past(lk_idx_r)] == can_tx_pkg::RES_ABORTED &&
        !req_r[$past(lk_idx_r)];
  endproperty
  a_single_shot: assert property (p_single_shot)
    else $error("single shot failure did not abort");

  property p_hold_chosen;
    lk_st_r == can_tx_pkg::LK_HELD && abt_r[lk_idx_r] && !outcome
    |=> req_r[$past(lk_idx_r)] && lk_st_r == can_tx_pkg::LK_HELD;
  endproperty
  a_hold_chosen: assert property (p_hold_chosen)
    else $error("chosen message aborted without loss or error");

  property p_abort_now;
    lk_st_r == can_tx_pkg::LK_IDLE && !eng_ev.start &&
    req_r[3] && abt_r[3]
    |=> res_r[3] == can_tx_pkg::RES_ABORTED && !req_r[3];
  endproperty
  a_abort_now: assert property (p_abort_now)
    else $error("idle buffer abort not completed at once");

  property p_request;
    wr_acc && region == can_tx_pkg::OFS_CTRL && mode_ok && !req_r[bidx] &&
    pwdata[can_tx_pkg::CTRL_REQ_BIT] && res_r[bidx] == can_tx_pkg::RES_NONE
    |=> req_r[$past(bidx)];
  endproperty
  a_request: assert property (p_request)
    else $error("request write did not set pending");

  property p_irq_done;
    (|(dn & ien_r)) |=> tx_irq;
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("enabled completion gave no transmit interrupt");

  property p_irq_no_abort;
    lk_st_r == can_tx_pkg::LK_HELD && eng_ev.done && abt_r[lk_idx_r] &&
    !ien_r[lk_idx_r] && ab == '0
    |=> !tx_irq;
  endproperty
  a_irq_no_abort: assert property (p_irq_no_abort)
    else $error("result 11 raised the abort interrupt");

  property p_hist;
    hist_push.valid |-> $past(hdte_r) && $past(hen_r) && $past(|dn);
  endproperty
  a_hist: assert property (p_hist)
    else $error("history push without all enables");

endmodule : can_tx_buffer_control

// ===== tb/eng_model.sv
// protocol engine stand-in: takes an offered buffer, reports one outcome
// assumes the offer and event carriers of can_tx_pkg, all on pclk
// ===========================================================================
// engine model
module eng_model (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire can_tx_pkg::tx_offer_type offer,
  input  wire logic                     go,
  input  wire logic [1:0]               outcome,
  input  wire logic [7:0]               lat,
  output can_tx_pkg::eng_event_type     eng_ev
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] cnt_r;

  // one message at a time; the gap after an outcome keeps a stale offer
  // from being taken twice, since the offer updates one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_ev <= '0;
      cnt_r  <= '0;
    end else begin
      eng_ev <= '0;
      if (cnt_r != 9'h0) cnt_r <= cnt_r - 9'h1;
      if (cnt_r == 9'h3) begin
        eng_ev.done     <= (outcome == 2'h0);
        eng_ev.arb_lost <= (outcome == 2'h1);
        eng_ev.error    <= (outcome == 2'h2);
      end else if (cnt_r == 9'h0 && go && offer.valid === 1'b1) begin
        eng_ev.start <= 1'b1;
        cnt_r        <= {1'b0, lat} + 9'h4;
      end
    end
  end
endmodule : eng_model

// ===== tb/can_tx_buffer_control_tb_top.sv
// self-checking bench: apb register calls against the engine model
// assumes zero wait apb slave and the map of can_tx_pkg
// ===========================================================================
// bench top
module can_tx_buffer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      pclk = 1'b0;
  logic                      presetn, psel, penable, pwrite, go, err;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, q;
  logic [5:0]                hidx;
  logic                      pready, pslverr, tx_irq;
  logic [1:0]                outcome;
  logic [7:0]                lat;
  can_tx_pkg::eng_event_type eng_ev;
  can_tx_pkg::tx_offer_type  offer, ofr;
  can_tx_pkg::tx_sel_type    hist_push;
  int                        failures, comparisons, irqs, hists, starts;

  can_tx_buffer_control u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eng_ev(eng_ev), .offer(offer),
    .tx_irq(tx_irq), .hist_push(hist_push));

  eng_model u_eng (.pclk(pclk), .presetn(presetn), .offer(offer),
    .go(go), .outcome(outcome), .lat(lat), .eng_ev(eng_ev));

  always #25 pclk = ~pclk;

  // ========================================================================
  // event counters, sampled mid-cycle so no race with the checking tasks
  always @(negedge pclk) begin
    if (tx_irq === 1'b1) irqs++;
    if (hist_push.valid === 1'b1) begin
      hists++;
      hidx = hist_push.index;
    end
    if (eng_ev.start === 1'b1) begin
      starts++;
      ofr = offer;
    end
  end

  // ========================================================================
  // tasks
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; an idle edge first so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ad(input logic [11:0] b, input int i);
    return b + 12'(4 * i);
  endfunction : ad

  // polls status until idle; a hang leaves pending set and ends the run as failed
  task automatic res(input int i, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, ad(can_tx_pkg::OFS_STAT, i), 32'h0);
      n++;
    end while (q[2] !== 1'b0 && n < 100);
    if (q[2] !== 1'b0) begin
      failures++;
      complete_run();
    end
    chk(q, exp);
  endtask : res

  task automatic wait_ev(input logic [3:0] m);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((4'(eng_ev) & m) == 4'h0 && n < 200);
    if (n >= 200) begin
      failures++;
      complete_run();
    end
  endtask : wait_ev

  // ========================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    outcome = 2'h0;
    lat = 8'h02;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, can_tx_pkg::OFS_CHCTL, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, can_tx_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, can_tx_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    // halt mode refuses control writes just as reset mode does
    apb(1'b1, can_tx_pkg::OFS_CHCTL, 32'h2);
    apb(1'b1, can_tx_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, can_tx_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h500, 32'h0);
    chk({q[31:1], err}, 32'h1);
    apb(1'b1, can_tx_pkg::OFS_CHCTL, 32'h100);
    // only buffer 0 raises the completion interrupt
    apb(1'b1, can_tx_pkg::OFS_IEN_LO, 32'h1);
    apb(1'b1, can_tx_pkg::OFS_HIST, 32'h3);
    // no buffer here has a pending request, so these id writes are allowed
    apb(1'b1, ad(can_tx_pkg::OFS_ID, 63), 32'h1abc);
    apb(1'b0, ad(can_tx_pkg::OFS_ID, 63), 32'h0);
    chk(q, 32'h1abc);
    apb(1'b1, ad(can_tx_pkg::OFS_ID, 0), 32'h8000_0123);
    apb(1'b1, ad(can_tx_pkg::OFS_DATA, 0), 32'hcafe_0001);
    apb(1'b1, can_tx_pkg::OFS_CTRL, 32'h1);
    apb(1'b0, can_tx_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h4);
    go <= 1'b1;
    res(0, 32'h2);
    chk({3'h0, ofr.id}, 32'h123);
    chk(ofr.data, 32'hcafe_0001);
    chk({26'h0, ofr.index}, 32'h0);
    chk(irqs, 1);
    chk({26'h0, hidx}, 32'h0);
    // the result clear is legal in standby as well as in communication
    apb(1'b1, can_tx_pkg::OFS_CHCTL, 32'h103);
    apb(1'b1, can_tx_pkg::OFS_STAT, 32'h0);
    apb(1'b0, can_tx_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, can_tx_pkg::OFS_CHCTL, 32'h100);
    // a lost arbitration keeps the message and sends it again
    outcome <= 2'h1;
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 1), 32'h1);
    wait_ev(4'h2);
    outcome <= 2'h0;
    res(1, 32'h2);
    chk(starts, 3);
    chk(irqs, 1);
    // single shot gives up on the first error
    outcome <= 2'h2;
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 2), 32'h5);
    res(2, 32'h1);
    chk(irqs, 2);
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 2), 32'h1);
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 2), 32'h0);
    apb(1'b0, ad(can_tx_pkg::OFS_STAT, 2), 32'h0);
    chk(q, 32'h1);
    // a waiting message is aborted at once
    go <= 1'b0;
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 3), 32'h1);
    apb(1'b1, ad(can_tx_pkg::OFS_ID, 3), 32'h7ff);
    apb(1'b0, ad(can_tx_pkg::OFS_ID, 3), 32'h0);
    chk(q, 32'h0);
    apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 3), 32'h3);
    res(3, 32'h1);
    chk(irqs, 3);
    // a chosen message waits for its outcome: 11 when sent, 01 on loss;
    // buffer 4 has no completion enable, so 11 must raise nothing
    lat <= 8'h1e;
    go <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      outcome <= 2'(k);
      apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 4 + k), 32'h1);
      wait_ev(4'h8);
      apb(1'b1, ad(can_tx_pkg::OFS_CTRL, 4 + k), 32'h3);
      apb(1'b0, ad(can_tx_pkg::OFS_STAT, 4 + k), 32'h0);
      chk(q, 32'h4);
      res(4 + k, 32'(3 - 2 * k));
      chk(irqs, 3 + k);
    end
    chk(hists, 1);
    complete_run();
  end
endmodule : can_tx_buffer_control_tb_top
